/* File: src/prp_pkg.sv */
// constants, codes and carriers shared by the pixel readback and pack unit
// assumes a 32-bit avalon slave with byte addresses and one word per register
package prp_pkg;
	localparam logic [5:0] REG_CTRL   = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h04;
	localparam logic [5:0] REG_ORIGIN = 6'h08;
	localparam logic [5:0] REG_SIZE   = 6'h0c;
	localparam logic [5:0] REG_FMT    = 6'h10;
	localparam logic [5:0] REG_DEST   = 6'h14;
	localparam logic [5:0] REG_ROWLEN = 6'h18;
	localparam logic [5:0] REG_SKIP   = 6'h1c;
	localparam logic [5:0] REG_ALIGN  = 6'h20;
	localparam logic [5:0] REG_BUFSZ  = 6'h24;
	localparam logic [5:0] REG_LIMIT  = 6'h28;
	localparam int         REG_LAST   = 10;
	localparam logic [31:0] ALIGN_RST = 32'h4;
	// field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_PACK  = 1;
	localparam int CTRL_READ  = 2;
	localparam int CTRL_LIMIT = 3;
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_ERR     = 2;
	localparam int ST_CAUSE   = 4;
	localparam int FLD_HI     = 16;
	localparam int FLD_TYPE   = 8;
	localparam int FLD_KIND   = 16;
	localparam int FLD_PRES   = 20;
	// format codes: bit 2 marks an integer format, low bits are element count less one
	localparam logic [2:0] FMT_RGB      = 3'h2;
	localparam int         FMT_INT_BIT  = 2;
	// component types
	localparam logic [3:0] TY_UBYTE  = 4'h0;
	localparam logic [3:0] TY_BYTE   = 4'h1;
	localparam logic [3:0] TY_USHORT = 4'h2;
	localparam logic [3:0] TY_SHORT  = 4'h3;
	localparam logic [3:0] TY_UINT   = 4'h4;
	localparam logic [3:0] TY_INT    = 4'h5;
	localparam logic [3:0] TY_HALF   = 4'h6;
	localparam logic [3:0] TY_FLOAT  = 4'h7;
	localparam logic [3:0] TY_R11G11B10 = 4'h8;
	// colour buffer kinds: bit 1 marks integer
	localparam logic [1:0] KD_UNORM = 2'h0;
	localparam logic [1:0] KD_FLOAT = 2'h1;
	localparam logic [1:0] KD_SINT  = 2'h2;
	// error causes, all reported as illegal operation
	localparam logic [3:0] EC_INTNESS = 4'h1;
	localparam logic [3:0] EC_TYPE    = 4'h2;
	localparam logic [3:0] EC_OVERRUN = 4'h3;
	localparam logic [3:0] EC_ALIGN   = 4'h4;
	localparam logic [3:0] EC_LIMIT   = 4'h5;
	localparam logic [31:0] ONE_FLOAT = 32'h3f800000;
	localparam logic [31:0] ONE_UNORM = 32'h000000ff;
	localparam logic [31:0] ONE_INT   = 32'h00000001;

	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] g;
		logic [31:0] r;
	} prp_pix_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] data;
	} prp_mem_t;
endpackage

/* File: src/prp_unit.sv */
// pixel readback and pack unit: register slave, pixel fetch, conversion, pack writes
// assumes a pixel source answering pix_req with pix_ack and a word memory stalling on mem_wait
`timescale 1ns/10ps
module prp_unit
	import prp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             pix_req,
	output logic      [15:0] pix_x,
	output logic      [15:0] pix_y,
	input  wire logic        pix_ack,
	input  wire prp_pix_t    pix_data,
	output prp_mem_t         mem,
	input  wire logic        mem_wait
);
	typedef enum logic [2:0] {S_IDLE, S_CALC, S_CHECK, S_FETCH, S_WRITE} prp_state_t;

	function automatic logic [31:0] u8_to_f(logic [7:0] c);
		logic [23:0] q;
		logic [23:0] m;
		int          p;
		q = {c, c, c};
		p = 0;
		for (int b = 0; b < 24; b++)
			if (q[b])
				p = b;
		m = q << (5'(23 - p));
		if (c == 8'h00)
			return 32'h0;
		if (c == 8'hff)
			return ONE_FLOAT;
		return {1'b0, 8'(103 + p), m[22:0]};
	endfunction

	// clamp to [0,1] then scale by maxv with rounding; denormals read as zero
	function automatic logic [31:0] f2n(logic [31:0] f, logic [31:0] maxv);
		logic [79:0] v;
		logic [7:0]  e;
		e = f[30:23];
		v = 80'h0;
		if (f[31] || e == 8'h00 || (e == 8'hff && f[22:0] != 23'h0))
			return 32'h0;
		if (e >= 8'd127)
			return maxv;
		if (8'd150 - e < 8'd64)
			v = ({56'h0, 1'b1, f[22:0]} << 40) >> (8'd150 - e);
		v = v * {48'h0, maxv} + (80'h1 << 39);
		return v[71:40];
	endfunction

	function automatic logic [15:0] f2h(logic [31:0] f);
		logic [7:0] e;
		e = f[30:23];
		if (e == 8'hff)
			return {f[31], 5'h1f, f[22:0] != 23'h0, 9'h0};
		if (e > 8'd142)
			return {f[31], 15'h7c00};
		if (e < 8'd113)
			return {f[31], 15'h0};
		return {f[31], 5'(e - 8'd112), f[22:13]};
	endfunction

	// unsigned small float; negatives other than NaN give zero, tiny values flush to zero
	function automatic logic [10:0] f2uf(logic [31:0] f, logic wide);
		logic [7:0] e;
		logic [4:0] x;
		logic [5:0] m;
		e = f[30:23];
		x = 5'(e - 8'd112);
		m = wide ? f[22:17] : {1'b0, f[22:18]};
		if (e == 8'hff && f[22:0] != 23'h0)
			return 11'h7ff;
		if (f[31] || e < 8'd113)
			return 11'h0;
		if (e > 8'd142)
			return wide ? {5'h1f, 6'h0} : {1'b0, 5'h1f, 5'h0};
		return wide ? {x, m} : {1'b0, x, m[4:0]};
	endfunction

	function automatic logic [31:0] sat(logic [31:0] v, logic sgn, logic [3:0] ty);
		logic signed [33:0] x;
		logic signed [33:0] lo;
		logic signed [33:0] hi;
		x = sgn ? {{2{v[31]}}, v} : {2'b00, v};
		lo = -34'sh80000000;
		hi = 34'sh0ffffffff;
		case (ty)
			TY_UBYTE:  begin lo = 34'sh0; hi = 34'shff; end
			TY_BYTE:   begin lo = -34'sh80; hi = 34'sh7f; end
			TY_USHORT: begin lo = 34'sh0; hi = 34'shffff; end
			TY_SHORT:  begin lo = -34'sh8000; hi = 34'sh7fff; end
			TY_UINT:   begin lo = 34'sh0; hi = 34'shffffffff; end
			TY_INT:    begin lo = -34'sh80000000; hi = 34'sh7fffffff; end
			default:   ;
		endcase
		if (x < lo)
			x = lo;
		else if (x > hi)
			x = hi;
		return x[31:0];
	endfunction

	function automatic logic [31:0] to_f(logic [31:0] v, logic [1:0] kind);
		return (kind == KD_UNORM) ? u8_to_f(v[7:0]) : v;
	endfunction

	function automatic logic [31:0] conv(logic [31:0] v, logic [1:0] kind, logic [3:0] ty);
		logic [31:0] f;
		f = to_f(v, kind);
		if (kind[1])
			return sat(v, kind == KD_SINT, ty);
		case (ty)
			TY_UBYTE:  return f2n(f, 32'h000000ff);
			TY_BYTE:   return f2n(f, 32'h0000007f);
			TY_USHORT: return f2n(f, 32'h0000ffff);
			TY_SHORT:  return f2n(f, 32'h00007fff);
			TY_UINT:   return f2n(f, 32'hffffffff);
			TY_INT:    return f2n(f, 32'h7fffffff);
			TY_HALF:   return {16'h0, f2h(f)};
			default:   return f;
		endcase
	endfunction

	function automatic prp_mem_t mk_wr(logic [31:0] a, logic [31:0] v, logic [2:0] sz);
		prp_mem_t m;
		m.we = 1'b1;
		m.addr = {a[31:2], 2'b00};
		m.be = (sz == 3'd1 ? 4'h1 : sz == 3'd2 ? 4'h3 : 4'hf) << a[1:0];
		m.data = v << {a[1:0], 3'b000};
		return m;
	endfunction

	logic [31:0] regs [0:REG_LAST];
	logic        done;
	logic        err;
	logic [3:0]  cause;
	prp_state_t  state;
	logic [15:0] col;
	logic [15:0] row;
	logic [1:0]  k;
	logic [31:0] stride;
	logic [31:0] end_off;
	logic [31:0] ea;
	logic [31:0] elem [0:3];
	logic [31:0] rd_mux;
	logic [31:0] row_len;
	logic [31:0] gbytes;
	logic [31:0] grp;
	logic [31:0] fin [0:3];
	logic [31:0] comp [0:3];
	logic [31:0] one;
	logic [10:0] uf_r;
	logic [10:0] uf_g;
	logic [10:0] uf_b;
	logic [2:0]  esz;
	logic [1:0]  n_last;
	logic [3:0]  errs;
	logic [15:0] next_col;
	logic [15:0] next_row;
	logic        wr_acc;
	logic        start;
	logic        last_pix;
	logic        done_ev;
	logic        err_ev;

	wire [15:0] ox        = regs[REG_ORIGIN[5:2]][15:0];
	wire [15:0] oy        = regs[REG_ORIGIN[5:2]][FLD_HI +: 16];
	wire [15:0] w         = regs[REG_SIZE[5:2]][15:0];
	wire [15:0] h         = regs[REG_SIZE[5:2]][FLD_HI +: 16];
	wire [2:0]  fmt       = regs[REG_FMT[5:2]][2:0];
	wire [3:0]  ty        = regs[REG_FMT[5:2]][FLD_TYPE +: 4];
	wire [1:0]  kind      = regs[REG_FMT[5:2]][FLD_KIND +: 2];
	wire [2:0]  present   = regs[REG_FMT[5:2]][FLD_PRES +: 3];
	wire [31:0] dest      = regs[REG_DEST[5:2]];
	wire [31:0] align     = regs[REG_ALIGN[5:2]];
	wire        pack_bnd  = regs[REG_CTRL[5:2]][CTRL_PACK];
	wire        read_bnd  = regs[REG_CTRL[5:2]][CTRL_READ];
	wire        limited   = regs[REG_CTRL[5:2]][CTRL_LIMIT];
	wire        flt_ty    = ty == TY_HALF || ty == TY_FLOAT || ty == TY_R11G11B10;

	assign wr_acc = avs_write && !avs_waitrequest;
	assign start = wr_acc && avs_address == REG_CTRL && avs_byteenable[0]
		&& avs_writedata[CTRL_START] && state == S_IDLE;

	// register slave: one wait cycle, then the access completes
	always_comb
	begin
		rd_mux = 32'h0;
		if (avs_address == REG_STATUS)
			rd_mux = {24'h0, cause, 1'b0, err, done, state != S_IDLE};
		else if (avs_address[1:0] == 2'b00 && int'(avs_address[5:2]) <= REG_LAST)
			rd_mux = regs[avs_address[5:2]];
	end

	always_ff @(posedge core_clk)
		if (!rst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end
		else if (ce)
		begin
			if (avs_waitrequest && (avs_read || avs_write))
			begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= rd_mux;
			end
			else
				avs_waitrequest <= 1'b1;
		end

	// command fields are used live, the issuer keeps them still while busy
	always_ff @(posedge core_clk)
		if (!rst_n)
		begin
			for (int r = 0; r <= REG_LAST; r++)
				regs[r] <= 32'h0;
			regs[REG_ALIGN[5:2]] <= ALIGN_RST;
		end
		else if (ce && wr_acc && avs_address != REG_STATUS && avs_address[1:0] == 2'b00
			&& int'(avs_address[5:2]) <= REG_LAST)
		begin
			for (int b = 0; b < 4; b++)
				if (avs_byteenable[b])
					regs[avs_address[5:2]][8*b +: 8] <= avs_writedata[8*b +: 8];
			if (avs_address == REG_CTRL)
				regs[REG_CTRL[5:2]][CTRL_START] <= 1'b0;
		end

	// any status write clears; a new event in the same cycle wins
	always_ff @(posedge core_clk)
		if (!rst_n)
		begin
			done <= 1'b0;
			err <= 1'b0;
			cause <= 4'h0;
		end
		else if (ce)
		begin
			if (done_ev)
				done <= 1'b1;
			else if (wr_acc && avs_address == REG_STATUS)
				done <= 1'b0;
			if (err_ev)
			begin
				err <= 1'b1;
				cause <= errs;
			end
			else if (wr_acc && avs_address == REG_STATUS)
			begin
				err <= 1'b0;
				cause <= 4'h0;
			end
		end

	// sizes and placement of groups
	always_comb
	begin
		case (ty)
			TY_UBYTE, TY_BYTE:               esz = 3'd1;
			TY_USHORT, TY_SHORT, TY_HALF:    esz = 3'd2;
			default:                         esz = 3'd4;
		endcase
		n_last = (ty == TY_R11G11B10) ? 2'd0 : fmt[1:0];
		gbytes = (32'(n_last) + 32'h1) * 32'(esz);
		row_len = (regs[REG_ROWLEN[5:2]] != 32'h0) ? regs[REG_ROWLEN[5:2]] : 32'(w);
		grp = dest + (32'(regs[REG_SKIP[5:2]][FLD_HI +: 16]) + 32'(row)) * stride
			+ (32'(regs[REG_SKIP[5:2]][15:0]) + 32'(col)) * gbytes;
		errs = 4'h0;
		if (fmt[FMT_INT_BIT] != kind[1])
			errs = EC_INTNESS;
		else if ((fmt[FMT_INT_BIT] && flt_ty) || (kind == KD_FLOAT && !flt_ty))
			errs = EC_TYPE;
		else if (pack_bnd && 33'(dest) + 33'(end_off) > 33'(regs[REG_BUFSZ[5:2]]))
			errs = EC_OVERRUN;
		else if (pack_bnd && (dest & (32'(esz) - 32'h1)) != 32'h0)
			errs = EC_ALIGN;
		else if (limited && end_off > regs[REG_LIMIT[5:2]])
			errs = EC_LIMIT;
	end

	// component fill and conversion of the incoming pixel
	always_comb
	begin
		one = (kind == KD_UNORM) ? ONE_UNORM : (kind == KD_FLOAT) ? ONE_FLOAT : ONE_INT;
		comp[0] = pix_data.r;
		comp[1] = (read_bnd && present < 3'd2) ? 32'h0 : pix_data.g;
		comp[2] = (read_bnd && present < 3'd3) ? 32'h0 : pix_data.b;
		comp[3] = (read_bnd && present < 3'd4) ? one : pix_data.a;
		for (int c = 0; c < 4; c++)
			fin[c] = conv(comp[c], kind, ty);
		uf_r = f2uf(to_f(comp[0], kind), 1'b1);
		uf_g = f2uf(to_f(comp[1], kind), 1'b1);
		uf_b = f2uf(to_f(comp[2], kind), 1'b0);
		if (ty == TY_R11G11B10 && fmt == FMT_RGB)
			fin[0] = {uf_b[9:0], uf_g, uf_r};
		last_pix = (col == w - 16'h1) && (row == h - 16'h1);
		next_col = (col == w - 16'h1) ? 16'h0 : col + 16'h1;
		next_row = (col == w - 16'h1) ? row + 16'h1 : row;
		err_ev = state == S_CHECK && errs != 4'h0;
		done_ev = (state == S_CHECK && errs == 4'h0 && (w == 16'h0 || h == 16'h0))
			|| (state == S_WRITE && !mem_wait && k == n_last && last_pix);
	end

	// sequencer; fetched values are not checked, the source owns window bounds
	always_ff @(posedge core_clk)
		if (!rst_n)
		begin
			state <= S_IDLE;
			col <= 16'h0;
			row <= 16'h0;
			k <= 2'd0;
			stride <= 32'h0;
			ea <= 32'h0;
			pix_req <= 1'b0;
			pix_x <= 16'h0;
			pix_y <= 16'h0;
			mem <= '0;
			for (int c = 0; c < 4; c++)
				elem[c] <= 32'h0;
		end
		else if (ce)
			case (state)
				S_IDLE:
					if (start)
						state <= S_CALC;
				S_CALC:
				begin
					// rows start on the pack alignment, a power of two
					stride <= (row_len * gbytes + align - 32'h1) & ~(align - 32'h1);
					state <= S_CHECK;
				end
				S_CHECK:
					if (errs != 4'h0 || w == 16'h0 || h == 16'h0)
						state <= S_IDLE;
					else
					begin
						col <= 16'h0;
						row <= 16'h0;
						pix_req <= 1'b1;
						pix_x <= ox;
						pix_y <= oy;
						state <= S_FETCH;
					end
				S_FETCH:
					if (pix_ack)
					begin
						pix_req <= 1'b0;
						for (int c = 0; c < 4; c++)
							elem[c] <= fin[c];
						mem <= mk_wr(grp, fin[0], esz);
						ea <= grp + 32'(esz);
						k <= 2'd0;
						state <= S_WRITE;
					end
				S_WRITE:
					if (!mem_wait)
					begin
						if (k == n_last)
						begin
							mem.we <= 1'b0;
							if (last_pix)
								state <= S_IDLE;
							else
							begin
								col <= next_col;
								row <= next_row;
								pix_req <= 1'b1;
								pix_x <= ox + next_col;
								pix_y <= oy + next_row;
								state <= S_FETCH;
							end
						end
						else
						begin
							mem <= mk_wr(ea, elem[k + 2'd1], esz);
							ea <= ea + 32'(esz);
							k <= k + 2'd1;
						end
					end
				default:
					state <= S_IDLE;
			endcase

	// end of the rectangle relative to the destination, registered in S_CALC on the same edge as stride
	always_ff @(posedge core_clk)
		if (!rst_n)
			end_off <= 32'h0;
		else if (ce && state == S_CALC)
			end_off <= (32'(regs[REG_SKIP[5:2]][FLD_HI +: 16]) + 32'(h) - 32'h1)
				* ((row_len * gbytes + align - 32'h1) & ~(align - 32'h1))
				+ (32'(regs[REG_SKIP[5:2]][15:0]) + 32'(w)) * gbytes;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_bus_wait: assert property (ce && avs_waitrequest && (avs_read || avs_write)
		|=> !avs_waitrequest) else $error("slave did not answer after one wait cycle");
	chk_fetch_pos: assert property (pix_req |-> pix_x == ox + col && pix_y == oy + row)
		else $error("fetch position off the rectangle");
	chk_intness: assert property (ce && state == S_CHECK && fmt[FMT_INT_BIT] != kind[1]
		|=> err && cause == EC_INTNESS) else $error("integer mismatch not flagged");
	chk_type_err: assert property (ce && state == S_CHECK && kind == KD_FLOAT && !flt_ty
		&& !fmt[FMT_INT_BIT] |=> err && cause == EC_TYPE) else $error("float type misuse missed");
	chk_overrun: assert property (ce && state == S_CHECK && errs == EC_OVERRUN
		|=> state == S_IDLE ##1 !mem.we) else $error("overrun did not stop transfer");
	chk_align_err: assert property (state == S_CHECK && pack_bnd && fmt[FMT_INT_BIT] == kind[1]
		&& errs != EC_TYPE && errs != EC_OVERRUN && dest[0] && esz != 3'd1
		|-> errs == EC_ALIGN) else $error("misaligned offset accepted");
	chk_no_write: assert property (mem.we |-> state == S_WRITE)
		else $error("memory write outside a transfer");
	chk_first_addr: assert property (ce && state == S_FETCH && pix_ack
		|=> mem.we && mem.addr == {$past(grp[31:2]), 2'b00}) else $error("group address wrong");
	chk_alpha_one: assert property (read_bnd && present == 3'd1 && kind[1]
		|-> comp[3] == ONE_INT && comp[1] == 32'h0) else $error("missing components not filled");
	chk_sat_low: assert property (kind == KD_SINT && ty == TY_UBYTE && pix_data.r[31]
		|-> fin[0] == 32'h0) else $error("negative integer not saturated");
	chk_elem_cnt: assert property (state == S_WRITE |-> k <= n_last)
		else $error("too many elements written");
	chk_limit: assert property (ce && state == S_CHECK && errs == EC_LIMIT
		|=> err && cause == EC_LIMIT) else $error("size limit not flagged");

	cov_done_ok: cover property (done_ev && !err_ev && state == S_WRITE);
	cov_error: cover property (err_ev);
	cov_packed: cover property (mem.we && ty == TY_R11G11B10);
	cov_pack_buf: cover property (mem.we && pack_bnd && mem_wait);
endmodule // prp_unit

/* File: sim/prp_far_model.sv */
// far side of the unit: pixel source answering pix_req, byte memory taking pack writes
// assumes the bench sets the pixel value, coordinate marking and stall mode
`timescale 1ns/10ps
module prp_far_model
	import prp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        xy_mark,
	input  wire prp_pix_t    pv,
	input  wire logic        pix_req,
	input  wire logic [15:0] pix_x,
	input  wire logic [15:0] pix_y,
	output logic             pix_ack,
	output prp_pix_t         pix_data,
	input  wire prp_mem_t    mem,
	output logic             mem_wait
);
	logic [7:0] bytes [int];
	int         wr_cnt = 0;
	logic [1:0] dly;
	prp_pix_t   val;

	always_comb
	begin
		val = pv;
		if (xy_mark)
			val.r = pv.r + {24'h0, pix_x[3:0], pix_y[3:0]};
	end

	// outside the ack cycle the bus shows the inverse, so a late sample reads wrong
	assign pix_data = pix_ack ? val : ~val;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pix_ack  <= 1'b0;
			dly      <= 2'h0;
			mem_wait <= 1'b0;
		end
		else
		begin
			pix_ack  <= 1'b0;
			mem_wait <= slow & ~mem_wait;
			if (pix_req && !pix_ack)
			begin
				if (dly == (slow ? 2'h2 : 2'h0))
				begin
					pix_ack <= 1'b1;
					dly     <= 2'h0;
				end
				else
					dly <= dly + 2'h1;
			end
		end
	end

	always @(posedge core_clk)
	begin
		if (rst_n && mem.we && !mem_wait)
		begin
			wr_cnt = wr_cnt + 1;
			for (int l = 0; l < 4; l++)
				if (mem.be[l])
					bytes[int'(mem.addr) + l] = mem.data[8*l +: 8];
		end
	end
endmodule // prp_far_model

/* File: sim/tb.sv */
// bench for the pixel readback and pack unit: avalon register tasks and command scenarios
// assumes prp_unit and prp_far_model; expectations come from the register layout
`timescale 1ns/10ps
module tb
	import prp_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	logic        ce;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pix_req;
	logic [15:0] pix_x;
	logic [15:0] pix_y;
	logic        pix_ack;
	prp_pix_t    pix_data;
	prp_mem_t    mem;
	logic        mem_wait;
	logic        slow;
	logic        xy_mark;
	prp_pix_t    pv;
	logic [31:0] cf [9];
	logic [31:0] st;
	int          err_total = 0;
	int          tests_run = 0;
	int          w0;
	int          ga;

	prp_unit uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pix_req(pix_req), .pix_x(pix_x), .pix_y(pix_y),
		.pix_ack(pix_ack), .pix_data(pix_data), .mem(mem), .mem_wait(mem_wait));

	prp_far_model far (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .xy_mark(xy_mark),
		.pv(pv), .pix_req(pix_req), .pix_x(pix_x), .pix_y(pix_y), .pix_ack(pix_ack),
		.pix_data(pix_data), .mem(mem), .mem_wait(mem_wait));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100)
		begin
			chk("bus answer", 32'h1, 32'h0);
			print_verdict();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, st);
		chk(what, st, exp);
	endtask

	function automatic logic [31:0] fw(input logic [2:0] f, input logic [3:0] t,
		input logic [1:0] k, input logic [2:0] p);
		return {9'h0, p, 2'h0, k, 4'h0, t, 5'h0, f};
	endfunction

	function automatic logic [31:0] rdm(input int a, input int n);
		logic [31:0] v;
		v = 32'h0;
		for (int l = 0; l < n; l++)
			v[8*l +: 8] = far.bytes[a + l];
		return v;
	endfunction

	// command fields stay untouched until status shows the end
	task automatic run(input logic [31:0] ctrl);
		int n;
		for (int k = 0; k < 9; k++)
			wr(6'h08 + 6'(4*k), cf[k]);
		wr(REG_STATUS, 32'h0);
		w0 = far.wr_cnt;
		wr(REG_CTRL, ctrl | 32'h1);
		n = 0;
		do
		begin
			bus(1'b0, REG_STATUS, 32'h0, st);
			n++;
		end
		while ((st[ST_BUSY] || !(st[ST_DONE] || st[ST_ERR])) && n < 300);
		if (n >= 300)
		begin
			chk("command end", 32'h1, 32'h0);
			print_verdict();
		end
	endtask

	task automatic err_case(input logic [31:0] f, input logic [31:0] ctrl,
		input logic [31:0] dest, input logic [31:0] bsz, input logic [31:0] lim,
		input logic [3:0] cause);
		cf = '{32'h0, 32'h00010001, f, dest, 32'h0, 32'h0, ALIGN_RST, bsz, lim};
		run(ctrl);
		chk("err flag", 32'(st[ST_ERR]), 32'h1);
		chk("err cause", 32'(st[7:4]), 32'(cause));
		chk("writes on error", 32'(far.wr_cnt - w0), 32'h0);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		slow = 1'b0;
		xy_mark = 1'b0;
		pv = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd_chk("align reset", REG_ALIGN, ALIGN_RST);
		rd_chk("status reset", REG_STATUS, 32'h0);
		wr(6'h2c, 32'hffffffff);
		rd_chk("unmapped read", 6'h2c, 32'h0);
		rd_chk("unaligned read", 6'h02, 32'h0);
		wr(REG_ORIGIN, 32'h12345678);
		rd_chk("origin back", REG_ORIGIN, 32'h12345678);
		$display("test registers done");
		// slow source and stalling memory, skips, row length and alignment 8
		slow <= 1'b1;
		xy_mark <= 1'b1;
		pv <= '{a:32'hff, b:32'h80, g:32'h40, r:32'h0};
		cf = '{32'h00050003, 32'h00020002, fw(3'h3, TY_UBYTE, KD_UNORM, 3'h4), 32'h100,
			32'h3, 32'h00010001, 32'h8, 32'h0, 32'h0};
		run(32'h0);
		chk("rect done", 32'(st[ST_DONE]), 32'h1);
		chk("rect writes", 32'(far.wr_cnt - w0), 32'h10);
		for (int j = 0; j < 2; j++)
			for (int i = 0; i < 2; i++)
			begin
				ga = 32'h100 + (1 + j) * 16 + (1 + i) * 4;
				chk("rect red", rdm(ga, 1), {24'h0, 4'(3 + i), 4'(5 + j)});
				chk("rect gba", rdm(ga + 1, 3), 32'hff8040);
			end
		$display("test rectangle done");
		slow <= 1'b0;
		xy_mark <= 1'b0;
		for (int f = 0; f < 4; f++)
		begin
			cf = '{32'h0, 32'h00010001, fw(3'(f), TY_UBYTE, KD_UNORM, 3'h4),
				32'h200 + 32'(f * 16), 32'h0, 32'h0, ALIGN_RST, 32'h0, 32'h0};
			run(32'h0);
			chk("elements per group", 32'(far.wr_cnt - w0), 32'(f + 1));
		end
		pv <= '{a:32'h33, b:32'h22, g:32'h11, r:32'h44};
		cf[2] = fw(3'h3, TY_UBYTE, KD_UNORM, 3'h1);
		cf[3] = 32'h300;
		run(32'h4);
		chk("missing parts", rdm(32'h300, 4), 32'hff000044);
		// pack buffer that ends exactly at the last byte written
		cf[2] = fw(3'h3, TY_UBYTE, KD_UNORM, 3'h4);
		cf[3] = 32'h8;
		cf[7] = 32'hc;
		run(32'h2);
		chk("pack fit err", 32'(st[ST_ERR]), 32'h0);
		chk("pack offset data", rdm(32'h8, 4), 32'h33221144);
		$display("test formats done");
		pv <= '{a:32'h3f800000, b:32'h0, g:32'hbf800000, r:32'h40000000};
		cf[2] = fw(3'h3, TY_FLOAT, KD_FLOAT, 3'h4);
		cf[3] = 32'h400;
		cf[7] = 32'h0;
		run(32'h0);
		chk("float red", rdm(32'h400, 4), 32'h40000000);
		chk("float green", rdm(32'h404, 4), 32'hbf800000);
		pv <= '{a:32'h0, b:32'h3f800000, g:32'h40000000, r:32'h3f800000};
		cf[2] = fw(FMT_RGB, TY_R11G11B10, KD_FLOAT, 3'h4);
		cf[3] = 32'h500;
		run(32'h0);
		chk("packed writes", 32'(far.wr_cnt - w0), 32'h1);
		chk("packed word", rdm(32'h500, 4), 32'h782003c0);
		pv <= '{a:32'hffffff00, b:32'h5, g:32'hffff0000, r:32'h00012345};
		cf[2] = fw(3'h7, TY_SHORT, KD_SINT, 3'h4);
		cf[3] = 32'h600;
		run(32'h0);
		chk("sat red green", rdm(32'h600, 4), 32'h80007fff);
		chk("sat blue alpha", rdm(32'h604, 4), 32'hff000005);
		// integer surface read through a bound target with red only present
		cf[2] = fw(3'h7, TY_INT, KD_SINT, 3'h1);
		cf[3] = 32'h700;
		run(32'h4);
		chk("int red", rdm(32'h700, 4), 32'h00012345);
		chk("int fill green", rdm(32'h704, 4), 32'h0);
		chk("int alpha one", rdm(32'h70c, 4), 32'h1);
		$display("test conversions done");
		err_case(fw(3'h7, TY_UINT, KD_UNORM, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_INTNESS);
		err_case(fw(3'h3, TY_UBYTE, KD_SINT, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_INTNESS);
		err_case(fw(3'h7, TY_FLOAT, KD_SINT, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_TYPE);
		err_case(fw(3'h7, TY_HALF, KD_SINT, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_TYPE);
		err_case(fw(3'h7, TY_R11G11B10, KD_SINT, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_TYPE);
		err_case(fw(3'h3, TY_UBYTE, KD_FLOAT, 3'h4), 32'h0, 32'h0, 32'h0, 32'h0, EC_TYPE);
		err_case(fw(3'h3, TY_UBYTE, KD_UNORM, 3'h4), 32'h2, 32'h0, 32'h3, 32'h0, EC_OVERRUN);
		err_case(fw(3'h3, TY_USHORT, KD_UNORM, 3'h4), 32'h2, 32'h1, 32'h40, 32'h0, EC_ALIGN);
		err_case(fw(3'h3, TY_UBYTE, KD_UNORM, 3'h4), 32'h8, 32'h0, 32'h0, 32'h3, EC_LIMIT);
		rd_chk("sticky err", REG_STATUS, 32'h54);
		wr(REG_STATUS, 32'h0);
		rd_chk("status cleared", REG_STATUS, 32'h0);
		$display("test errors done");
		print_verdict();
	end
endmodule // tb
